//--- core/brc_reset_ctrl.v
// Summary of operation
// - Bidirectional reset enable is locked after end of init; every reset clears it.
// - In bidirectional mode the reset flags always report a long hardware reset.
// - In bidirectional mode any reset samples the port configuration; low boot bit starts loader.
// - In bidirectional mode a short hardware reset is stretched to the full sequence.
// - One extension enable bit, config bit 2, enables extension RAM and CAN together.
// - A disabled extension module decodes no addresses and claims no pins.
// - In bidirectional mode the reset pin is pulled low for the whole sequence.
// - Reset indication output is low during any reset until end of init.
`timescale 1ns/1ps
`default_nettype none
`include "brc_consts.vh"

module brc_reset_ctrl #(
  parameter SEQ_CYC = `BRC_SEQ_CYC,
  parameter HW_LONG_CYC = `BRC_HW_LONG_CYC,
  parameter PORT_W = 16
) (
  input wire ref_clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire resetPinIn,
  output reg resetPinOut,
  output reg resetPinOe,
  input wire watchdogReset,
  input wire [PORT_W-1:0] lowAddrDataPortIn,
  output reg resetIndicationN,
  output reg sysResetN,
  output reg [PORT_W-1:0] portConfig,
  output reg bootstrapStart,
  output reg xramDecodeEn,
  output reg canDecodeEn,
  output reg canPinClaim,
  output reg irq
);
  // ----------------------------------------
  // States and sizes
  // ----------------------------------------
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_PINLOW = 4'b0010;
  localparam [3:0] ST_SEQ = 4'b0100;
  localparam [3:0] ST_BLANK = 4'b1000;
  localparam CW = 16;
  localparam [CW-1:0] SEQ_LAST = SEQ_CYC - 1;
  localparam [CW-1:0] LONG_MIN = HW_LONG_CYC;
  localparam [CW-1:0] BLANK_LAST = `BRC_BLANK_CYC - 1;
  localparam [31:0] SYSCFG_RST = `BRC_SYSCFG_RST;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire pinLevel;
  wire [PORT_W-1:0] portLevel;

  brc_sync #(.WIDTH(1), .INIT(1'b1)) uPinSync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(resetPinIn),
    .dout(pinLevel)
  );

  brc_sync #(.WIDTH(PORT_W), .INIT({PORT_W{1'b1}})) uPortSync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din(lowAddrDataPortIn),
    .dout(portLevel)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [3:0] state_r;
  reg [CW-1:0] cnt_r;
  reg seqBidir_r;
  reg seqSample_r;
  reg xperiph_enable_r;
  reg bidir_r;
  reg einitDone_r;
  reg flagHwLong_r;
  reg flagHwShort_r;
  reg flagSw_r;
  reg flagWdt_r;
  reg [2:0] intStat_r;
  reg [2:0] intEn_r;
  reg swReq_r;
  reg wdtSeen_r;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire apbAcc = psel & penable & pready;
  wire apbWr = apbAcc & pwrite;
  wire selSyscfg = (paddr == `BRC_OFF_SYSCFG);
  wire selStatus = (paddr == `BRC_OFF_STATUS);
  wire selCmd = (paddr == `BRC_OFF_CMD);
  wire selIntStat = (paddr == `BRC_OFF_INT_STAT);
  wire selIntClr = (paddr == `BRC_OFF_INT_CLR);
  wire selIntEn = (paddr == `BRC_OFF_INT_EN);
  wire selPort = (paddr == `BRC_OFF_PORTCFG);
  wire mapped = selSyscfg | selStatus | selCmd | selIntStat | selIntClr | selIntEn | selPort;
  wire inRun = state_r[0];
  wire einitCmd = apbWr & selCmd & pwdata[`BRC_CMD_END_OF_INIT_INSTR] & inRun;
  wire swCmd = apbWr & selCmd & pwdata[`BRC_CMD_SWRST] & inRun;
  wire cfgWr = apbWr & selSyscfg & inRun & ~einitDone_r;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  wire startReset = inRun & (~pinLevel | swReq_r | wdtSeen_r);
  wire seqEnd = state_r[2] & (cnt_r == SEQ_LAST);
  wire shortEnd = state_r[1] & pinLevel & (cnt_r < LONG_MIN);
  reg [3:0] state_nxt;

  always @* begin
    case (state_r)
      ST_RUN: begin
        if (!startReset) begin
          state_nxt = ST_RUN;
        end else if (!pinLevel && !bidir_r) begin
          state_nxt = ST_PINLOW;
        end else begin
          state_nxt = ST_SEQ;
        end
      end
      ST_PINLOW: begin
        if (!pinLevel) begin
          state_nxt = ST_PINLOW;
        end else if (cnt_r < LONG_MIN) begin
          state_nxt = ST_BLANK;
        end else begin
          state_nxt = ST_SEQ;
        end
      end
      ST_SEQ: begin
        state_nxt = seqEnd ? ST_BLANK : ST_SEQ;
      end
      ST_BLANK: begin
        state_nxt = (cnt_r == BLANK_LAST) ? ST_RUN : ST_BLANK;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_SEQ;
      cnt_r <= {CW{1'b0}};
      seqBidir_r <= 1'b0;
      seqSample_r <= 1'b1;
      swReq_r <= 1'b0;
      wdtSeen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= {CW{1'b0}};
      end else if (cnt_r != {CW{1'b1}}) begin
        cnt_r <= cnt_r + 1'b1;
      end
      swReq_r <= swCmd;
      wdtSeen_r <= watchdogReset & inRun;
      if (startReset) begin
        seqBidir_r <= bidir_r;
        seqSample_r <= bidir_r | ~pinLevel;
      end
    end
  end

  // ----------------------------------------
  // Config and reset flags
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xperiph_enable_r <= SYSCFG_RST[`BRC_SYSCFG_XPERIPH_ENABLE];
      bidir_r <= 1'b0;
      einitDone_r <= 1'b0;
      flagHwLong_r <= 1'b1;
      flagHwShort_r <= 1'b0;
      flagSw_r <= 1'b0;
      flagWdt_r <= 1'b0;
    end else if (startReset) begin
      xperiph_enable_r <= 1'b0;
      bidir_r <= 1'b0;
      einitDone_r <= 1'b0;
      flagHwLong_r <= bidir_r | ~pinLevel;
      flagHwShort_r <= 1'b0;
      flagSw_r <= ~bidir_r & pinLevel & swReq_r;
      flagWdt_r <= ~bidir_r & pinLevel & ~swReq_r;
    end else begin
      if (shortEnd) begin
        flagHwLong_r <= 1'b0;
        flagHwShort_r <= 1'b1;
      end
      if (cfgWr) begin
        xperiph_enable_r <= pwdata[`BRC_SYSCFG_XPERIPH_ENABLE];
        bidir_r <= pwdata[`BRC_SYSCFG_BIDIR];
      end
      if (einitCmd) begin
        einitDone_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  wire [2:0] intEvt;
  assign intEvt[`BRC_IRQ_SEQ_DONE] = seqEnd | shortEnd;
  assign intEvt[`BRC_IRQ_END_OF_INIT_INSTR] = einitCmd;
  assign intEvt[`BRC_IRQ_BOOT] = seqEnd & seqSample_r & ~portLevel[`BRC_PORT_BOOT_BIT];
  wire [2:0] intClr = (apbWr & selIntClr) ? pwdata[2:0] : 3'h0;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      intStat_r <= 3'h0;
      intEn_r <= `BRC_IRQ_EN_RST;
      irq <= 1'b0;
    end else begin
      // Set wins over clear
      intStat_r <= (intStat_r & ~intClr) | intEvt;
      if (apbWr && selIntEn) begin
        intEn_r <= pwdata[2:0];
      end
      irq <= |(((intStat_r & ~intClr) | intEvt) & intEn_r);
    end
  end

  // ----------------------------------------
  // Pin and system outputs
  // ----------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b0;
      resetIndicationN <= 1'b0;
      sysResetN <= 1'b0;
      portConfig <= {PORT_W{1'b1}};
      bootstrapStart <= 1'b0;
      xramDecodeEn <= 1'b0;
      canDecodeEn <= 1'b0;
      canPinClaim <= 1'b0;
    end else begin
      resetPinOut <= 1'b0;
      resetPinOe <= (state_nxt == ST_SEQ) & (startReset ? bidir_r : seqBidir_r);
      if (state_nxt != ST_RUN && state_nxt != ST_BLANK) begin
        resetIndicationN <= 1'b0;
      end else if (einitCmd) begin
        resetIndicationN <= 1'b1;
      end
      sysResetN <= (state_nxt == ST_RUN) | (state_nxt == ST_BLANK);
      if (seqEnd && seqSample_r) begin
        portConfig <= portLevel;
        bootstrapStart <= ~portLevel[`BRC_PORT_BOOT_BIT];
      end else if (startReset) begin
        bootstrapStart <= 1'b0;
      end
      // Drop at the reset edge itself, not one cycle later
      xramDecodeEn <= xperiph_enable_r & (state_nxt == ST_RUN);
      canDecodeEn <= xperiph_enable_r & (state_nxt == ST_RUN);
      canPinClaim <= xperiph_enable_r & (state_nxt == ST_RUN);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  reg [31:0] rdata;

  always @* begin
    rdata = 32'h0000_0000;
    if (selSyscfg) begin
      rdata[`BRC_SYSCFG_XPERIPH_ENABLE] = xperiph_enable_r;
      rdata[`BRC_SYSCFG_BIDIR] = bidir_r;
    end else if (selStatus) begin
      rdata[`BRC_ST_HW_LONG] = flagHwLong_r;
      rdata[`BRC_ST_HW_SHORT] = flagHwShort_r;
      rdata[`BRC_ST_SW] = flagSw_r;
      rdata[`BRC_ST_WDT] = flagWdt_r;
      rdata[`BRC_ST_END_OF_INIT_INSTR_DONE] = einitDone_r;
      rdata[`BRC_ST_BIDIR_SEQ] = seqBidir_r;
      rdata[`BRC_ST_IN_RESET] = ~inRun;
    end else if (selIntStat) begin
      rdata[2:0] = intStat_r;
    end else if (selIntEn) begin
      rdata[2:0] = intEn_r;
    end else if (selPort) begin
      rdata[PORT_W-1:0] = portConfig;
      rdata[PORT_W] = bootstrapStart;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdata;
      end
    end
  end
endmodule

`default_nettype wire

//--- core/brc_consts.vh
`ifndef BRC_CONSTS_VH
`define BRC_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BRC_OFF_SYSCFG 8'h00
`define BRC_OFF_STATUS 8'h04
`define BRC_OFF_CMD 8'h08
`define BRC_OFF_INT_STAT 8'h0C
`define BRC_OFF_INT_CLR 8'h10
`define BRC_OFF_INT_EN 8'h14
`define BRC_OFF_PORTCFG 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BRC_SYSCFG_XPERIPH_ENABLE 2
`define BRC_SYSCFG_BIDIR 3
`define BRC_CMD_END_OF_INIT_INSTR 0
`define BRC_CMD_SWRST 1
`define BRC_ST_HW_LONG 0
`define BRC_ST_HW_SHORT 1
`define BRC_ST_SW 2
`define BRC_ST_WDT 3
`define BRC_ST_END_OF_INIT_INSTR_DONE 4
`define BRC_ST_BIDIR_SEQ 5
`define BRC_ST_IN_RESET 6
`define BRC_IRQ_SEQ_DONE 0
`define BRC_IRQ_END_OF_INIT_INSTR 1
`define BRC_IRQ_BOOT 2
`define BRC_PORT_BOOT_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BRC_SYSCFG_RST 32'h0000_0000
`define BRC_IRQ_EN_RST 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define BRC_CLK_MHZ 200
`define BRC_SEQ_NS 5120
`define BRC_HW_LONG_NS 1000
`define BRC_SEQ_CYC ((`BRC_SEQ_NS * `BRC_CLK_MHZ + 999) / 1000)
`define BRC_HW_LONG_CYC ((`BRC_HW_LONG_NS * `BRC_CLK_MHZ + 999) / 1000)
`define BRC_BLANK_CYC 4

`endif

//--- core/brc_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module brc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  integer i;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      dout <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Bit changes only once stages two and three agree
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- tb/brc_rst_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Open-drain external reset source
// ----------------------------------------
module brc_rst_src (
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [7:0] len,
  output logic pullOe
);
  logic [7:0] cnt_r = 8'h00;
  // Pulls low only, never drives high
  always @(posedge ref_clk) begin
    if (start) begin
      cnt_r <= len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign pullOe = (cnt_r != 8'h00);
endmodule
`default_nettype wire

//--- tb/brc_reset_checker.sv
`timescale 1ns/1ps
`default_nettype none
module brc_reset_checker #(
  parameter SEQ_CYC = 16,
  parameter PORT_W = 16
) (
  input wire ref_clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire resetPinOut,
  input wire resetPinOe,
  input wire resetIndicationN,
  input wire sysResetN,
  input wire [PORT_W-1:0] portConfig,
  input wire bootstrapStart,
  input wire xramDecodeEn,
  input wire canDecodeEn,
  input wire canPinClaim
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] oeCnt_r;
  // Length of the current pin pull
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      oeCnt_r <= 16'h0000;
    end else if (resetPinOe) begin
      oeCnt_r <= oeCnt_r + 16'h0001;
    end else begin
      oeCnt_r <= 16'h0000;
    end
  end
  AST_OE_LEN: assert property ($fell(resetPinOe) |-> oeCnt_r == SEQ_CYC)
    else $error("pin pull length wrong");
  AST_OE_SYS: assert property (resetPinOe |-> !sysResetN && !resetIndicationN)
    else $error("pin pulled outside reset");
  AST_PIN0: assert property (resetPinOut == 1'h0)
    else $error("reset pin driven high");
  AST_IND: assert property (!sysResetN |-> !resetIndicationN)
    else $error("indication high in reset");
  AST_IND_RISE: assert property ($rose(resetIndicationN) |-> $past(sysResetN))
    else $error("indication rose in reset");
  AST_XP_EQ: assert property (xramDecodeEn == canDecodeEn && canDecodeEn == canPinClaim)
    else $error("extension enables differ");
  AST_XP_OFF: assert property (!sysResetN |-> !xramDecodeEn && !canPinClaim)
    else $error("extension active in reset");
  AST_BOOT: assert property (sysResetN |-> bootstrapStart == !portConfig[4])
    else $error("bootstrap disagrees with port");
  AST_RDY: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without access");
endmodule
bind brc_reset_ctrl brc_reset_checker #(.SEQ_CYC(SEQ_CYC), .PORT_W(PORT_W)) i_brc_reset_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .resetIndicationN(resetIndicationN),
  .sysResetN(sysResetN), .portConfig(portConfig), .bootstrapStart(bootstrapStart),
  .xramDecodeEn(xramDecodeEn), .canDecodeEn(canDecodeEn), .canPinClaim(canPinClaim)
);
`default_nettype wire

//--- tb/brc_reset_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "brc_consts.vh"
module brc_reset_ctrl_tb;
  localparam int SEQ = 16;
  logic ref_clk, arst_n, psel, penable, pwrite, wdt, srcGo, e;
  logic [7:0] paddr, srcLen;
  logic [31:0] pwdata, q;
  logic [15:0] portIn;
  wire [31:0] prdata;
  wire pready, pslverr, pinOut, pinOe, indN, sysN, boot, extension_ram, can, canPin, irq, srcOe;
  wire [15:0] portCfg;
  // Pull-up on the pin, either side may pull low
  wire pinLvl = !(srcOe | pinOe);
  integer n_mismatch, total_checks;
  always #2.5 ref_clk = !ref_clk;
  brc_reset_ctrl #(.SEQ_CYC(SEQ), .HW_LONG_CYC(4), .PORT_W(16)) i_brc_reset_ctrl (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPinIn(pinLvl), .resetPinOut(pinOut), .resetPinOe(pinOe), .watchdogReset(wdt),
    .lowAddrDataPortIn(portIn), .resetIndicationN(indN), .sysResetN(sysN), .portConfig(portCfg),
    .bootstrapStart(boot), .xramDecodeEn(extension_ram), .canDecodeEn(can), .canPinClaim(canPin), .irq(irq));
  brc_rst_src i_brc_rst_src (.ref_clk(ref_clk), .start(srcGo), .len(srcLen), .pullOe(srcOe));
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      total_checks++;
      if (g !== x) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task hang;
    begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      i = 0;
      @(posedge ref_clk);
      while (pready !== 1'h1 && i < 20) begin
        @(posedge ref_clk);
        i++;
      end
      if (i >= 20) hang;
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    begin
      apb(1'h0, a, 32'h0);
      chk(q & m, x);
    end
  endtask
  task tick;
    repeat (3) @(posedge ref_clk);
  endtask
  // Waits out one reset sequence, counting pin-pull cycles
  task seq_wait(input integer expOe);
    integer i, n;
    logic seen;
    begin
      n = 0;
      seen = 0;
      for (i = 0; i < 400 && !(seen && sysN === 1'h1); i++) begin
        @(posedge ref_clk);
        if (sysN === 1'h0) seen = 1;
        if (pinOe === 1'h1) n++;
      end
      if (i >= 400) hang;
      chk(n, expOe);
      repeat (6) @(posedge ref_clk);
    end
  endtask
  initial begin
    ref_clk = 0;
    arst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wdt = 0;
    srcGo = 0;
    srcLen = 8'h00;
    portIn = 16'hFFFF;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    seq_wait(0);
    rd(`BRC_OFF_STATUS, 32'h1, 32'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("test power_reset done");
    apb(1'h1, `BRC_OFF_SYSCFG, 32'hC);
    tick;
    chk({extension_ram, can, canPin}, 3'h7);
    rd(`BRC_OFF_SYSCFG, 32'hC, 32'hC);
    apb(1'h1, `BRC_OFF_SYSCFG, 32'h0);
    tick;
    chk({extension_ram, can, canPin}, 3'h0);
    apb(1'h1, `BRC_OFF_SYSCFG, 32'hC);
    apb(1'h1, `BRC_OFF_INT_EN, 32'h0);
    apb(1'h1, `BRC_OFF_CMD, 32'h1);
    tick;
    chk(indN, 1'h1);
    rd(`BRC_OFF_STATUS, 32'h10, 32'h10);
    apb(1'h1, `BRC_OFF_SYSCFG, 32'h0);
    rd(`BRC_OFF_SYSCFG, 32'hC, 32'hC);
    rd(`BRC_OFF_INT_STAT, 32'h2, 32'h2);
    chk(irq, 1'h0);
    apb(1'h1, `BRC_OFF_INT_EN, 32'h7);
    tick;
    chk(irq, 1'h1);
    apb(1'h1, `BRC_OFF_INT_CLR, 32'h7);
    tick;
    chk(irq, 1'h0);
    $display("test lock_and_irq done");
    portIn <= 16'hFFEF;
    apb(1'h1, `BRC_OFF_CMD, 32'h2);
    seq_wait(SEQ);
    chk(indN, 1'h0);
    chk({boot, portCfg}, 17'h1FFEF);
    rd(`BRC_OFF_STATUS, 32'h3F, 32'h21);
    rd(`BRC_OFF_SYSCFG, 32'hFFFFFFFF, 32'h0);
    $display("test bidir_soft done");
    portIn <= 16'hFFFF;
    apb(1'h1, `BRC_OFF_SYSCFG, 32'h8);
    srcLen <= 8'h03;
    srcGo <= 1'h1;
    @(posedge ref_clk);
    srcGo <= 1'h0;
    seq_wait(SEQ);
    rd(`BRC_OFF_STATUS, 32'h3, 32'h1);
    chk({boot, portCfg}, 17'h0FFFF);
    $display("test bidir_short done");
    wdt <= 1'h1;
    @(posedge ref_clk);
    wdt <= 1'h0;
    seq_wait(0);
    rd(`BRC_OFF_STATUS, 32'hF, 32'h8);
    chk(indN, 1'h0);
    $display("test watchdog done");
    apb(1'h1, `BRC_OFF_CMD, 32'h2);
    seq_wait(0);
    rd(`BRC_OFF_STATUS, 32'hF, 32'h4);
    srcLen <= 8'h03;
    srcGo <= 1'h1;
    @(posedge ref_clk);
    srcGo <= 1'h0;
    seq_wait(0);
    rd(`BRC_OFF_STATUS, 32'h3, 32'h2);
    chk({boot, portCfg}, 17'h0FFFF);
    $display("test plain_resets done");
    report_and_stop;
  end
endmodule
`default_nettype wire
